// ===== pdmc_board.sv
// board-side model: drives the reset, standby and nmi pins
// assumes: tasks are called by the bench just after a rising CLK edge
`timescale 1ns/1ps
module pdmc_board (
    input  wire logic clk,     // system clock
    output logic      res_n,   // reset pin, active low
    output logic      hw_standby_pin_n_n,  // standby pin, active low
    output logic      nmi      // nmi pin
);
    initial begin
        res_n = 1'b1;
        hw_standby_pin_n_n = 1'b1;
        nmi = 1'b0;
    end
    // -----------------------------
    // hardware standby sequencing
    // -----------------------------
    task automatic hw_enter();
        res_n <= 1'b0;
        repeat (4) @(posedge clk);
        // mode pins are strapped on the board and stay fixed through standby
        hw_standby_pin_n_n <= 1'b0;
    endtask
    task automatic nmi_set(input logic v);
        nmi <= v;
    endtask
    task automatic hw_exit(input int settle);
        hw_standby_pin_n_n <= 1'b1;
        repeat (settle) @(posedge clk);
        res_n <= 1'b1;
    endtask
endmodule

// ===== pdmc_params.svh
// power-down mode control: offsets, field positions, reset values, timing
// assumes: included by the settle timer and top design modules, not by the package
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH

// ----------------------------------------
// register byte offsets on APB
// ----------------------------------------
`define PDMC_OFS_SYSCTL     12'h000
`define PDMC_OFS_DIVCTL     12'h004
`define PDMC_OFS_MODSTOP    12'h008
`define PDMC_OFS_CONTROL   12'h00C
`define PDMC_OFS_STATUS     12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define PDMC_SYS_STANDBY_SELECT_BIT_BIT   7
`define PDMC_SYS_STS_LSB    4
`define PDMC_SYS_NMI_EDGE_SELECT_BIT  2
`define PDMC_SYS_RAM_ENABLE_BIT_BIT   0
`define PDMC_MST_CLOCK_OUT_STOP_BIT_BIT  7
`define PDMC_CTL_SLEEP_BIT  0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PDMC_SYSCTL_RST     8'h01
`define PDMC_DIVCTL_RST     8'h00
`define PDMC_MODSTOP_RST    8'h40
`define PDMC_MODSTOP_FIXED  8'h40
`define PDMC_READ_ONES      8'hFF

// ----------------------------------------
// settle wait state counts
// ----------------------------------------
`define PDMC_WAIT_000       18'h02000
`define PDMC_WAIT_001       18'h04000
`define PDMC_WAIT_010       18'h08000
`define PDMC_WAIT_011       18'h10000
`define PDMC_WAIT_100       18'h20000
`define PDMC_WAIT_101       18'h00400

`endif

// ===== pdmc_pkg.sv
// power-down mode control: shared types
// assumes: pdmc_params.svh exists alongside
package pdmc_pkg;
    typedef enum logic [1:0] {
        PDMC_NORMAL,
        PDMC_SLEEP,
        PDMC_SWSTBY,
        PDMC_SETTLE
    } pdmc_state_t;
endpackage

// ===== pdmc_settle_timer.sv
// power-down mode control: clock-settling wait counter
// assumes: one clock, start is a one-cycle pulse from the controller
`timescale 1ns/1ps
`include "pdmc_params.svh"

module pdmc_settle_timer #(
    parameter int CNT_W = 21
) (
    input  wire logic             clk,       // system clock
    input  wire logic             rst_n,     // async reset, active low
    input  wire logic             start,     // load and start the wait
    input  wire logic [2:0]       sel,       // oscillator-wait code
    input  wire logic [1:0]       div,       // divider code
    output logic                  done       // one-cycle pulse at end of wait
);
    logic [CNT_W-1:0] cnt_reg;
    logic             run_reg;
    logic [17:0]      states;

    if (CNT_W < 21) begin : g_bad_cnt_w
        $error("pdmc_settle_timer: CNT_W too small");
    end

    // state count selected by code; illegal codes take the longest
    always_comb begin
        case (sel)
            3'h0:    states = `PDMC_WAIT_000; // R4
            3'h1:    states = `PDMC_WAIT_001;
            3'h2:    states = `PDMC_WAIT_010;
            3'h3:    states = `PDMC_WAIT_011;
            3'h4:    states = `PDMC_WAIT_100;
            3'h5:    states = `PDMC_WAIT_101;
            default: states = `PDMC_WAIT_100;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                // each divider step doubles the wait
                cnt_reg <= CNT_W'({3'h0, states} << div) - CNT_W'(1); // R5
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg == '0) begin
                    run_reg <= 1'b0;
                    done    <= 1'b1; // R1
                end else begin
                    cnt_reg <= cnt_reg - CNT_W'(1);
                end
            end
        end
    end
endmodule

// ===== pdmc_top.sv
// power-down mode control: standby modes, module stop and clock out gating
// assumes: APB slave on CLK; pins from board arrive asynchronous
// Functional notes
// (R1) after wake interrupt, count selected states before clocks and interrupt handling
// (R2) software keeps crystal settle wait at least 7 ms
// (R3) with external clock any wait setting is acceptable
// (R4) wait codes 0..5 give 8192,16384,32768,65536,131072,1024 states
// (R5) settle wait is states times divided clock period; divider doubles
// (R6) sleep with standby bit set halts clock, resets DMA and modules
// (R7) software sequences NMI edge and standby bit before sleeping
// (R8) rising NMI edge wakes standby when edge select is rising
// (R9) ports hold their outputs during software standby
// (R10) standby pin low forces hardware standby from any state
// (R11) hardware standby resets all but RAM and floats ports
// (R12) software clears RAM enable before standby pin falls
// (R13) board holds mode pins steady during hardware standby
// (R14) standby rise with reset low starts oscillator; reset rise runs program
// (R15) board drives reset low first, raises standby first
// (R16) module stop bit halts module from the next bus cycle
// (R17) stopped module reads all ones, writes discarded
// (R18) stopping a module initialises its registers
// (R19) software avoids stopping DMA or refresh while they request bus
// (R20) software disables module interrupts before stopping it
// (R21) stopped module pins revert to generic port behaviour
// (R22) module stop register writable by CPU only, not by DMA
// (R23) clock out stop bit floats clock pin, clear enables it
// (R24) clock pin toggles, high in software standby, floats otherwise
`timescale 1ns/1ps
`include "pdmc_params.svh"

module pdmc_top #(
    parameter int NMOD = 6
) (
    input  wire logic             CLK,          // system clock 50 MHz
    input  wire logic             RSTN,         // async reset, active low
    input  wire logic             PSEL,         // apb select
    input  wire logic             PENABLE,      // apb enable
    input  wire logic             PWRITE,       // apb direction
    input  wire logic [11:0]      PADDR,        // apb byte address
    input  wire logic [31:0]      PWDATA,       // apb write data
    input  wire logic             PDMA_MASTER,  // access comes from DMA
    output logic      [31:0]      PRDATA,       // apb read data
    output logic                  PREADY,       // apb ready
    output logic                  PSLVERR,      // apb error
    input  wire logic             RESET_PIN_N,  // reset pin, active low
    input  wire logic             HW_STANDBY_PIN_N, // standby pin, active low
    input  wire logic             NMI_PIN,      // nmi pin
    input  wire logic             WAKE_IRQ,     // enabled external irq, same clock
    input  wire logic [NMOD-1:0]  MOD_RD_REQ,   // peripheral register read
    input  wire logic [NMOD-1:0]  MOD_WR_REQ,   // peripheral register write
    output logic      [NMOD-1:0]  MOD_RD_FORCE_ONES, // force read data to all ones
    output logic      [NMOD-1:0]  MOD_WR_ALLOW, // write passes to peripheral
    output logic      [NMOD-1:0]  MOD_RESET_N,  // peripheral reset, active low
    output logic      [NMOD-1:0]  MOD_CLK_EN,   // peripheral clock enable
    output logic      [NMOD-1:0]  MOD_PIN_GENERIC, // pins revert to port
    output logic                  CPU_CLK_EN,   // cpu clock enable
    output logic                  CPU_RESET_N,  // cpu reset, active low
    output logic                  INT_START,    // begin interrupt handling, pulse
    output logic                  OSC_EN,       // oscillator enable
    output logic                  PORT_HOLD,    // ports hold outputs
    output logic                  PORT_HIZ,     // ports high impedance
    output logic                  RAM_ENABLE,   // on-chip ram enabled
    output logic                  CLKOUT_O,     // clock pin level
    output logic                  CLKOUT_OE     // clock pin drive enable
);
    logic [1:0]      res_sync_reg;
    logic [1:0]      hw_standby_pin_n_sync_reg;
    logic [1:0]      nmi_sync_reg;
    logic            nmi_prev_reg;
    logic [7:0]      system_control_reg;
    logic [7:0]      divider_control_reg;
    logic [7:0]      module_stop_ctrl_reg;
    logic [NMOD-1:0] stop_eff_reg;
    logic            clk_div_reg;
    pdmc_pkg::pdmc_state_t state_reg;
    logic            settle_start_reg;
    logic            settle_done;
    logic            hwstby;
    logic            res_low;
    logic            nmi_rise;
    logic            nmi_fall;
    logic            nmi_wake;
    logic            acc;
    logic            wr;
    logic            sleep_cmd;

    if (NMOD != 6) begin : g_bad_nmod
        $error("pdmc_top: NMOD must be 6");
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            res_sync_reg  <= 2'h0;
            hw_standby_pin_n_sync_reg <= 2'h0;
            nmi_sync_reg  <= 2'h0;
            nmi_prev_reg  <= 1'b0;
        end else begin
            res_sync_reg  <= {res_sync_reg[0], RESET_PIN_N};
            hw_standby_pin_n_sync_reg <= {hw_standby_pin_n_sync_reg[0], HW_STANDBY_PIN_N};
            nmi_sync_reg  <= {nmi_sync_reg[0], NMI_PIN};
            nmi_prev_reg  <= nmi_sync_reg[1];
        end
    end

    assign hwstby   = !hw_standby_pin_n_sync_reg[1]; // R10
    assign res_low  = !res_sync_reg[1];
    assign nmi_rise = nmi_sync_reg[1] && !nmi_prev_reg;
    assign nmi_fall = !nmi_sync_reg[1] && nmi_prev_reg;
    assign nmi_wake = system_control_reg[`PDMC_SYS_NMI_EDGE_SELECT_BIT] ? nmi_rise : nmi_fall; // R8

    // ----------------------------------------
    // apb slave, zero wait
    // ----------------------------------------
    assign acc       = PSEL && PENABLE;
    assign wr        = acc && PWRITE;
    assign sleep_cmd = wr && (PADDR == `PDMC_OFS_CONTROL) && PWDATA[`PDMC_CTL_SLEEP_BIT];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            system_control_reg   <= `PDMC_SYSCTL_RST;
            divider_control_reg  <= `PDMC_DIVCTL_RST;
            module_stop_ctrl_reg <= `PDMC_MODSTOP_RST;
        end else if (hwstby || res_low) begin
            system_control_reg   <= `PDMC_SYSCTL_RST; // R11
            divider_control_reg  <= `PDMC_DIVCTL_RST;
            module_stop_ctrl_reg <= `PDMC_MODSTOP_RST;
        end else if (wr) begin
            case (PADDR)
                `PDMC_OFS_SYSCTL:  system_control_reg  <= PWDATA[7:0];
                `PDMC_OFS_DIVCTL:  divider_control_reg <= {6'h00, PWDATA[1:0]};
                `PDMC_OFS_MODSTOP: begin
                    if (!PDMA_MASTER) begin
                        module_stop_ctrl_reg <= PWDATA[7:0] | `PDMC_MODSTOP_FIXED; // R22
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PRDATA  <= 32'h00000000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `PDMC_OFS_SYSCTL:  PRDATA <= {24'h000000, system_control_reg};
                    `PDMC_OFS_DIVCTL:  PRDATA <= {24'h000000, divider_control_reg};
                    `PDMC_OFS_MODSTOP: PRDATA <= {24'h000000, module_stop_ctrl_reg};
                    `PDMC_OFS_CONTROL: PRDATA <= 32'h00000000;
                    `PDMC_OFS_STATUS:  PRDATA <= {28'h0000000, stop_eff_reg[1:0], 2'(state_reg)};
                    default:           PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg        <= pdmc_pkg::PDMC_NORMAL;
            settle_start_reg <= 1'b0;
            INT_START        <= 1'b0;
        end else begin
            settle_start_reg <= 1'b0;
            INT_START        <= 1'b0;
            if (hwstby || res_low) begin
                state_reg <= pdmc_pkg::PDMC_NORMAL; // R10
            end else begin
                case (state_reg)
                    pdmc_pkg::PDMC_NORMAL: begin
                        if (sleep_cmd) begin
                            state_reg <= system_control_reg[`PDMC_SYS_STANDBY_SELECT_BIT_BIT] ?
                                         pdmc_pkg::PDMC_SWSTBY : pdmc_pkg::PDMC_SLEEP; // R6
                        end
                    end
                    pdmc_pkg::PDMC_SLEEP: begin
                        if (WAKE_IRQ || nmi_wake) begin
                            state_reg <= pdmc_pkg::PDMC_NORMAL;
                            INT_START <= 1'b1;
                        end
                    end
                    pdmc_pkg::PDMC_SWSTBY: begin
                        if (WAKE_IRQ || nmi_wake) begin
                            state_reg        <= pdmc_pkg::PDMC_SETTLE; // R8
                            settle_start_reg <= 1'b1;
                        end
                    end
                    pdmc_pkg::PDMC_SETTLE: begin
                        if (settle_done) begin
                            state_reg <= pdmc_pkg::PDMC_NORMAL; // R1
                            INT_START <= 1'b1;
                        end
                    end
                    default: state_reg <= pdmc_pkg::PDMC_NORMAL;
                endcase
            end
        end
    end

    pdmc_settle_timer #(
        .CNT_W (21)
    ) u_settle (
        .clk   (CLK),
        .rst_n (RSTN),
        .start (settle_start_reg),
        .sel   (system_control_reg[`PDMC_SYS_STS_LSB +: 3]),
        .div   (divider_control_reg[1:0]),
        .done  (settle_done)
    );

    // ----------------------------------------
    // module standby, effective from next bus cycle
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            stop_eff_reg <= '0;
        end else begin
            stop_eff_reg <= module_stop_ctrl_reg[NMOD-1:0]; // R16
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MOD_RD_FORCE_ONES <= '0;
            MOD_WR_ALLOW      <= '0;
            MOD_RESET_N       <= '0;
            MOD_CLK_EN        <= '0;
            MOD_PIN_GENERIC   <= '0;
        end else begin
            for (int i = 0; i < NMOD; i++) begin
                MOD_RD_FORCE_ONES[i] <= MOD_RD_REQ[i] && stop_eff_reg[i]; // R17
                MOD_WR_ALLOW[i]      <= MOD_WR_REQ[i] && !stop_eff_reg[i]; // R17
                MOD_RESET_N[i]       <= !(stop_eff_reg[i] || hwstby || res_low ||
                                          state_reg == pdmc_pkg::PDMC_SWSTBY); // R18
                MOD_CLK_EN[i]        <= !(stop_eff_reg[i] || hwstby ||
                                          state_reg == pdmc_pkg::PDMC_SWSTBY ||
                                          state_reg == pdmc_pkg::PDMC_SETTLE); // R6
                MOD_PIN_GENERIC[i]   <= stop_eff_reg[i]; // R21
            end
        end
    end

    // ----------------------------------------
    // cpu, oscillator, ports, ram
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CPU_CLK_EN  <= 1'b0;
            CPU_RESET_N <= 1'b0;
            OSC_EN      <= 1'b0;
            PORT_HOLD   <= 1'b0;
            PORT_HIZ    <= 1'b1;
            RAM_ENABLE  <= 1'b0;
        end else begin
            CPU_CLK_EN  <= !hwstby && state_reg == pdmc_pkg::PDMC_NORMAL; // R6
            CPU_RESET_N <= !hwstby && !res_low; // R14
            OSC_EN      <= !hwstby && state_reg != pdmc_pkg::PDMC_SWSTBY; // R14
            PORT_HOLD   <= state_reg == pdmc_pkg::PDMC_SWSTBY ||
                           state_reg == pdmc_pkg::PDMC_SETTLE; // R9
            PORT_HIZ    <= hwstby; // R11
            RAM_ENABLE  <= system_control_reg[`PDMC_SYS_RAM_ENABLE_BIT_BIT] && !hwstby;
        end
    end

    // ----------------------------------------
    // system clock output pin
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            clk_div_reg <= 1'b0;
            CLKOUT_O    <= 1'b0;
            CLKOUT_OE   <= 1'b0;
        end else begin
            clk_div_reg <= !clk_div_reg;
            CLKOUT_OE   <= !hwstby && !module_stop_ctrl_reg[`PDMC_MST_CLOCK_OUT_STOP_BIT_BIT]; // R23
            if (state_reg == pdmc_pkg::PDMC_SWSTBY || state_reg == pdmc_pkg::PDMC_SETTLE) begin
                CLKOUT_O <= 1'b1; // R24
            end else begin
                CLKOUT_O <= clk_div_reg; // R24
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_stop_gates_write;
        @(posedge CLK) disable iff (!RSTN)
        (MOD_WR_ALLOW & $past(stop_eff_reg)) == '0;
    endproperty
    a_stop_gates_write: assert property (p_stop_gates_write) else $error("write passed to stopped module"); // R17

    property p_stop_forces_ones;
        @(posedge CLK) disable iff (!RSTN)
        (MOD_RD_FORCE_ONES & $past(stop_eff_reg)) == ($past(MOD_RD_REQ) & $past(stop_eff_reg));
    endproperty
    a_stop_forces_ones: assert property (p_stop_forces_ones) else $error("read of stopped module not forced"); // R17

    property p_stop_next_cycle;
        @(posedge CLK) disable iff (!RSTN)
        $rose(module_stop_ctrl_reg[3]) |=> stop_eff_reg[3] ##1 !MOD_RESET_N[3];
    endproperty
    a_stop_next_cycle: assert property (p_stop_next_cycle) else $error("module stop late"); // R16

    property p_dma_no_write;
        @(posedge CLK) disable iff (!RSTN)
        (wr && PDMA_MASTER && PADDR == `PDMC_OFS_MODSTOP && !hwstby && !res_low) |=> $stable(module_stop_ctrl_reg);
    endproperty
    a_dma_no_write: assert property (p_dma_no_write) else $error("dma changed module stop register"); // R22

    property p_clock_out_stop_bit_floats;
        @(posedge CLK) disable iff (!RSTN)
        module_stop_ctrl_reg[`PDMC_MST_CLOCK_OUT_STOP_BIT_BIT] |=> !CLKOUT_OE;
    endproperty
    a_clock_out_stop_bit_floats: assert property (p_clock_out_stop_bit_floats) else $error("clock pin driven while stopped"); // R23

    property p_swstby_high;
        @(posedge CLK) disable iff (!RSTN)
        (state_reg == pdmc_pkg::PDMC_SWSTBY) [*2] |-> CLKOUT_O;
    endproperty
    a_swstby_high: assert property (p_swstby_high) else $error("clock pin not high in standby"); // R24

    property p_hwstby_hiz;
        @(posedge CLK) disable iff (!RSTN)
        hwstby |=> PORT_HIZ && !CLKOUT_OE && !CPU_RESET_N;
    endproperty
    a_hwstby_hiz: assert property (p_hwstby_hiz) else $error("hardware standby not applied"); // R11

    property p_sleep_to_standby;
        @(posedge CLK) disable iff (!RSTN)
        (state_reg == pdmc_pkg::PDMC_NORMAL && sleep_cmd && system_control_reg[`PDMC_SYS_STANDBY_SELECT_BIT_BIT]
         && !hwstby && !res_low) |=> state_reg == pdmc_pkg::PDMC_SWSTBY ##1 !CPU_CLK_EN;
    endproperty
    a_sleep_to_standby: assert property (p_sleep_to_standby) else $error("software standby not entered"); // R6

    property p_settle_min;
        @(posedge CLK) disable iff (!RSTN)
        settle_start_reg |=> (!INT_START) [*8];
    endproperty
    a_settle_min: assert property (p_settle_min) else $error("interrupt started before settling"); // R1

    property p_nmi_rise_wakes;
        @(posedge CLK) disable iff (!RSTN)
        (state_reg == pdmc_pkg::PDMC_SWSTBY && nmi_rise && system_control_reg[`PDMC_SYS_NMI_EDGE_SELECT_BIT]
         && !hwstby && !res_low) |=> state_reg == pdmc_pkg::PDMC_SETTLE;
    endproperty
    a_nmi_rise_wakes: assert property (p_nmi_rise_wakes) else $error("rising nmi did not wake"); // R8

    property p_hold_in_standby;
        @(posedge CLK) disable iff (!RSTN)
        (state_reg == pdmc_pkg::PDMC_SWSTBY) |=> PORT_HOLD;
    endproperty
    a_hold_in_standby: assert property (p_hold_in_standby) else $error("ports not held"); // R9
endmodule

// ===== tb_top.sv
// self-checking bench for the power-down mode controller
// assumes: design answers apb in one access cycle; pins pass 2 sync stages
`timescale 1ns/1ps
module tb_top;
    logic        clk, rstn, psel, penable, pwrite, pdma, wake, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  mrd, mwr, rdf, wra, mrst, mcen, mpg;
    logic        cpu_ce, cpu_rn, int_start, osc, phold, phiz, ram_en, cko, ckoe;
    logic        res_n, hw_standby_pin_n_n, nmi, err;
    int          mismatches, checks_done, m, j, cnt, ex;
    pdmc_board board (.clk(clk), .res_n(res_n), .hw_standby_pin_n_n(hw_standby_pin_n_n), .nmi(nmi));
    pdmc_top uut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PDMA_MASTER(pdma), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RESET_PIN_N(res_n), .HW_STANDBY_PIN_N(hw_standby_pin_n_n), .NMI_PIN(nmi), .WAKE_IRQ(wake), .MOD_RD_REQ(mrd),
        .MOD_WR_REQ(mwr), .MOD_RD_FORCE_ONES(rdf), .MOD_WR_ALLOW(wra), .MOD_RESET_N(mrst), .MOD_CLK_EN(mcen),
        .MOD_PIN_GENERIC(mpg), .CPU_CLK_EN(cpu_ce), .CPU_RESET_N(cpu_rn), .INT_START(int_start), .OSC_EN(osc),
        .PORT_HOLD(phold), .PORT_HIZ(phiz), .RAM_ENABLE(ram_en), .CLKOUT_O(cko), .CLKOUT_OE(ckoe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // -----------------------------
    // shared tasks
    // -----------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic int settle_cycles(input int code, input int dv);
        int t[6] = '{8192, 16384, 32768, 65536, 131072, 1024};
        return t[code] << dv;
    endfunction
    task automatic results();
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
    // -----------------------------
    // main sequence
    // -----------------------------
    initial begin
        {rstn, psel, penable, pwrite, pdma, wake} = 6'h00;
        paddr = 12'h000; pwdata = 32'h00000000; mrd = 6'h00; mwr = 6'h00;
        mismatches = 0; checks_done = 0;
        void'($urandom(32'h4196));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        apb(0, 12'h000, 0); chk("sysctl", rd, 32'h01);
        apb(0, 12'h004, 0); chk("divctl", rd, 32'h00);
        apb(0, 12'h008, 0); chk("modstop", rd, 32'h40);
        apb(0, 12'h0F0, 0); chk("unmapped", {31'h0, err}, 1);
        m = $urandom % 6;
        j = (m + 1) % 6;
        apb(1, 12'h008, 32'h1 << m);
        repeat (3) @(posedge clk);
        mrd <= 6'h1 << m; mwr <= (6'h1 << m) | (6'h1 << j);
        @(posedge clk);
        mrd <= 6'h00; mwr <= 6'h00;
        #1;
        chk("rd ones", rdf[m], 1);
        chk("wr drop", wra[m], 0);
        chk("wr pass", wra[j], 1);
        chk("mod rst", mrst[m], 0);
        chk("generic", mpg[m], 1);
        chk("mod clk", {mcen[m], mcen[j]}, 2'b01);
        pdma <= 1'b1; apb(1, 12'h008, 32'h40); pdma <= 1'b0;
        apb(0, 12'h008, 0); chk("dma wr", rd, 32'h40 | (32'h1 << m));
        apb(1, 12'h008, 32'hC0);
        repeat (3) @(posedge clk); #1;
        chk("ck float", ckoe, 0);
        apb(1, 12'h008, 32'h40);
        repeat (3) @(posedge clk); #1;
        chk("ck drive", ckoe, 1);
        for (int dv = 0; dv < 2; dv++) begin
            // select rising-edge nmi wake and software standby, then sleep
            apb(1, 12'h004, dv);
            apb(1, 12'h000, 32'hD5);
            apb(1, 12'h00C, 32'h1);
            repeat (4) @(posedge clk); #1;
            chk("cpu halt", {cpu_ce, osc, mrst}, 8'h00);
            chk("hold", phold, 1);
            @(posedge clk); #1;
            chk("ck high", {ckoe, cko}, 2'b11);
            board.nmi_set(1'b1);
            ex = settle_cycles(5, dv);
            cnt = 0;
            while (int_start !== 1'b1 && cnt < 5000) begin
                @(posedge clk);
                cnt++;
            end
            chk("settle", {31'h0, cnt >= ex && cnt <= ex + 8}, 1);
            board.nmi_set(1'b0);
            repeat (4) @(posedge clk);
        end
        apb(1, 12'h000, 32'h55);
        apb(1, 12'h00C, 32'h1);
        apb(0, 12'h010, 0); chk("sleep st", rd[1:0], 2'h1);
        #1; ex = cko;
        @(posedge clk); #1;
        chk("ck sleep", {cpu_ce, cko}, {1'b0, ~ex[0]});
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        chk("sleep wake", int_start, 1);
        apb(1, 12'h008, 32'h3F);
        apb(1, 12'h000, 32'h54); #1;
        chk("ram off", ram_en, 0);
        board.hw_enter();
        repeat (5) @(posedge clk); #1;
        chk("hiz", {phiz, ckoe, mrst}, 8'h80);
        board.hw_exit(8);
        #1;
        chk("osc", {osc, cpu_rn}, 2'b10);
        repeat (6) @(posedge clk); #1;
        chk("run", cpu_rn, 1);
        apb(0, 12'h008, 0); chk("mst rst", rd, 32'h40);
        results();
    end
endmodule
